//--- verilog/led_pwm_pkg.sv
// Constants, types and colour table for the three-channel LED PWM controller.
// Assumes a single core clock at CLK_MHZ; register map is reached over a 2-wire bus.
package led_pwm_pkg;
  localparam int CLK_MHZ      = 250;
  localparam int FRAME_US     = 50;
  localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;
  localparam int CNT_W        = 16;

  // Register offsets and reset values
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_COLOR = 8'h01;
  localparam logic [7:0] OFS_ILIM  = 8'h02;
  localparam logic [7:0] CTRL_RST  = 8'h20;
  localparam logic [7:0] COLOR_RST = 8'h00;
  localparam logic [7:0] ILIM_RST  = 8'h00;

  // Control register fields
  localparam int BIT_PWM     = 7;
  localparam int BIT_EN      = 6;
  localparam int BIT_MODE    = 5;
  localparam int BIT_RED     = 3;
  localparam int BIT_GREEN   = 2;
  localparam int BIT_BLUE    = 1;
  localparam int BIT_OVERLAP = 0;
  // Colour/brightness and current-limit fields
  localparam int COLOR_HI  = 7;
  localparam int COLOR_LO  = 4;
  localparam int BRIGHT_HI = 3;
  localparam int BRIGHT_LO = 1;
  localparam int RED_CUR   = 4;
  localparam int GREEN_CUR = 2;
  localparam int BLUE_CUR  = 0;

  localparam logic [2:0] BRIGHT_MAX = 3'h7;
  localparam logic [3:0] SHARE_FULL = 4'hc;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  // Arbitrary bus address value
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

  typedef struct packed {logic red; logic green; logic blue;} rgb_t;
  typedef struct packed {logic [1:0] red; logic [1:0] green; logic [1:0] blue;} current_codes_t;
  typedef struct packed {logic [3:0] red; logic [3:0] green; logic [3:0] blue;} share_t;

  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_PTR, I2C_WDATA, I2C_ACK_ADDR, I2C_ACK_PTR,
    I2C_ACK_DATA, I2C_RDATA, I2C_RACK
  } i2c_state_t;

  // Colour shares in twelfths of the lit window
  function automatic share_t color_share(input logic [3:0] code);
    case (code)
      4'h0: color_share = '{4'hc, 4'h0, 4'h0};
      4'h1: color_share = '{4'h0, 4'hc, 4'h0};
      4'h2: color_share = '{4'h0, 4'h0, 4'hc};
      4'h3: color_share = '{4'h6, 4'h6, 4'h0};
      4'h4: color_share = '{4'h0, 4'h6, 4'h6};
      4'h5: color_share = '{4'h6, 4'h0, 4'h6};
      4'h6: color_share = '{4'h4, 4'h4, 4'h4};
      4'h7: color_share = '{4'h6, 4'h3, 4'h3};
      4'h8: color_share = '{4'h3, 4'h6, 4'h3};
      4'h9: color_share = '{4'h3, 4'h6, 4'h3};
      4'ha: color_share = '{4'h3, 4'h3, 4'h6};
      4'hb: color_share = '{4'h9, 4'h3, 4'h0};
      4'hc: color_share = '{4'h0, 4'h9, 4'h3};
      4'hd: color_share = '{4'h3, 4'h9, 4'h0};
      4'he: color_share = '{4'h0, 4'h3, 4'h9};
      default: color_share = '{4'h3, 4'h0, 4'h9};
    endcase
  endfunction : color_share
endpackage : led_pwm_pkg

//--- verilog/rgb_led_pwm_controller.sv
// Three-channel LED sink controller: 2-wire register slave, PWM frame engine.
// Assumes scl/sda and the external reset arrive asynchronously; pads resolve sda.
`timescale 1ns/1ps
module rgb_led_pwm_controller #(
  parameter int         FRAME_CYCLES = led_pwm_pkg::FRAME_CYCLES,
  parameter logic [6:0] DEV_ADDR     = led_pwm_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic                        core_clk,
  input  wire logic                        resetn,
  input  wire logic                        external_reset_n,
  input  wire logic                        scl_in,
  input  wire logic                        sda_in,
  output logic                             sda_out,
  output logic                             sda_oe_n,
  output led_pwm_pkg::rgb_t                sink_pin_oe_n,
  output logic                             sink_mode_select,
  output led_pwm_pkg::current_codes_t      current_codes
);
  localparam int CW = led_pwm_pkg::CNT_W;
  localparam int PW = CW + 4;
  localparam logic [CW-1:0] FRAME_LEN  = CW'(FRAME_CYCLES);
  localparam logic [CW-1:0] FRAME_LAST = CW'(FRAME_CYCLES - 1);

  typedef struct packed {
    logic                        ext_meta;
    logic                        ext_sync;
    logic                        scl_meta;
    logic                        scl_sync;
    logic                        scl_prev;
    logic                        sda_meta;
    logic                        sda_sync;
    logic                        sda_prev;
    led_pwm_pkg::i2c_state_t     i2c;
    logic [3:0]                  bit_cnt;
    logic [7:0]                  shift;
    logic [7:0]                  ptr;
    logic                        read_mode;
    logic                        master_nack;
    logic                        sda_oe_n;
    logic                        sda_out;
    logic [7:0]                  ctrl;
    logic [7:0]                  color;
    logic [7:0]                  ilim;
    logic [7:0]                  act_ctrl;
    logic [7:0]                  act_color;
    logic [CW-1:0]               frame_cnt;
    led_pwm_pkg::rgb_t           sink_oe_n;
    logic                        sink_mode;
    led_pwm_pkg::current_codes_t cur;
  } state_t;

  // Defaults; scl/sda sync stages idle high so release cannot fake a start
  function automatic state_t reset_value();
    state_t v;
    v           = '0;
    v.scl_meta  = 1'b1;
    v.scl_sync  = 1'b1;
    v.scl_prev  = 1'b1;
    v.sda_meta  = 1'b1;
    v.sda_sync  = 1'b1;
    v.sda_prev  = 1'b1;
    v.i2c       = led_pwm_pkg::I2C_IDLE;
    v.sda_oe_n  = 1'b1;
    v.ctrl      = led_pwm_pkg::CTRL_RST;
    v.color     = led_pwm_pkg::COLOR_RST;
    v.ilim      = led_pwm_pkg::ILIM_RST;
    v.act_ctrl  = led_pwm_pkg::CTRL_RST;
    v.act_color = led_pwm_pkg::COLOR_RST;
    v.sink_oe_n = '1;
    v.sink_mode = 1'b1;
    return v;
  endfunction : reset_value
  localparam state_t ST_RST = reset_value();
  state_t                 st;
  state_t                 next_st;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   bus_start;
  logic                   bus_stop;
  logic                   frame_end;
  logic [7:0]             read_data;
  logic [2:0]             bright;
  logic [CW-1:0]          win;
  led_pwm_pkg::share_t    share;
  logic [PW-1:0]          cnt12;
  logic [PW-1:0]          thr_r;
  logic [PW-1:0]          thr_rg;
  logic [PW-1:0]          thr_all;
  led_pwm_pkg::rgb_t      en;
  led_pwm_pkg::rgb_t      slot;
  led_pwm_pkg::rgb_t      on;
  // Bus edges come from the second and third stages only
  assign scl_rise  = st.scl_sync & ~st.scl_prev;
  assign scl_fall  = ~st.scl_sync & st.scl_prev;
  assign bus_start = st.scl_sync & st.scl_prev & st.sda_prev & ~st.sda_sync;
  assign bus_stop  = st.scl_sync & st.scl_prev & ~st.sda_prev & st.sda_sync;
  assign frame_end = (st.frame_cnt == FRAME_LAST);
  // Read mux; unmapped offsets read as zero
  always_comb begin
    case (st.ptr)
      led_pwm_pkg::OFS_CTRL:  read_data = st.ctrl;
      led_pwm_pkg::OFS_COLOR: read_data = st.color;
      led_pwm_pkg::OFS_ILIM:  read_data = st.ilim;
      default:                read_data = 8'h00;
    endcase
  end
  // Lit window: the frame halved once per step below full brightness, and empty at brightness zero
  assign bright = st.act_color[led_pwm_pkg::BRIGHT_HI:led_pwm_pkg::BRIGHT_LO];
  assign win    = (bright == 3'h0) ? '0 : (FRAME_LEN >> (led_pwm_pkg::BRIGHT_MAX - bright));
  assign share  = led_pwm_pkg::color_share(
                    st.act_color[led_pwm_pkg::COLOR_HI:led_pwm_pkg::COLOR_LO]);
  // Slot edges compared in twelfths so no divider is needed
  assign cnt12   = PW'(st.frame_cnt) * PW'(led_pwm_pkg::SHARE_FULL);
  assign thr_r   = PW'(win) * PW'(share.red);
  assign thr_rg  = PW'(win) * PW'(share.red + share.green);
  assign thr_all = PW'(win) * PW'(led_pwm_pkg::SHARE_FULL);
  // Red first, then green, then blue, all inside the lit window
  always_comb begin
    slot.red   = (cnt12 < thr_r);
    slot.green = (cnt12 >= thr_r) && (cnt12 < thr_rg);
    slot.blue  = (cnt12 >= thr_rg) && (cnt12 < thr_all);
  end
  // Output selection by mode
  always_comb begin
    en.red   = st.act_ctrl[led_pwm_pkg::BIT_RED];
    en.green = st.act_ctrl[led_pwm_pkg::BIT_GREEN];
    en.blue  = st.act_ctrl[led_pwm_pkg::BIT_BLUE];
    if (!st.act_ctrl[led_pwm_pkg::BIT_EN]) begin
      on = '0;
    end else if (!st.act_ctrl[led_pwm_pkg::BIT_PWM]) begin
      on = en;
    end else if (st.act_ctrl[led_pwm_pkg::BIT_OVERLAP]) begin
      on = en & {3{st.frame_cnt < win}};
    end else begin
      on = en & slot;
    end
  end

  // Next state: synchronisers, frame engine, register slave
  always_comb begin
    next_st          = st;
    next_st.ext_meta = external_reset_n;
    next_st.ext_sync = st.ext_meta;
    next_st.scl_meta = scl_in;
    next_st.scl_sync = st.scl_meta;
    next_st.scl_prev = st.scl_sync;
    next_st.sda_meta = sda_in;
    next_st.sda_sync = st.sda_meta;
    next_st.sda_prev = st.sda_sync;

    // Shadows load only at the boundary so a half-written setting never shows
    next_st.frame_cnt = frame_end ? '0 : st.frame_cnt + 1'b1;
    if (frame_end) begin
      next_st.act_ctrl  = st.ctrl;
      next_st.act_color = st.color;
    end
    next_st.sink_oe_n = ~on;
    next_st.sink_mode = st.act_ctrl[led_pwm_pkg::BIT_MODE];
    next_st.cur.red   = st.ilim[led_pwm_pkg::RED_CUR+:2];
    next_st.cur.green = st.ilim[led_pwm_pkg::GREEN_CUR+:2];
    next_st.cur.blue  = st.ilim[led_pwm_pkg::BLUE_CUR+:2];

    if (bus_start) begin
      next_st.i2c      = led_pwm_pkg::I2C_ADDR;
      next_st.bit_cnt  = 4'h0;
      next_st.sda_oe_n = 1'b1;
    end else if (bus_stop) begin
      next_st.i2c      = led_pwm_pkg::I2C_IDLE;
      next_st.sda_oe_n = 1'b1;
    end else begin
      case (st.i2c)
        led_pwm_pkg::I2C_IDLE: begin
          next_st.sda_oe_n = 1'b1;
        end
        led_pwm_pkg::I2C_ADDR, led_pwm_pkg::I2C_PTR, led_pwm_pkg::I2C_WDATA: begin
          if (scl_rise && st.bit_cnt != led_pwm_pkg::BYTE_BITS) begin
            next_st.shift   = {st.shift[6:0], st.sda_sync};
            next_st.bit_cnt = st.bit_cnt + 1'b1;
          end else if (scl_fall && st.bit_cnt == led_pwm_pkg::BYTE_BITS) begin
            next_st.bit_cnt = 4'h0;
            case (st.i2c)
              led_pwm_pkg::I2C_ADDR: begin
                if (st.shift[7:1] == DEV_ADDR) begin
                  next_st.read_mode = st.shift[0];
                  next_st.sda_oe_n  = 1'b0;
                  next_st.i2c       = led_pwm_pkg::I2C_ACK_ADDR;
                end else begin
                  next_st.i2c = led_pwm_pkg::I2C_IDLE;
                end
              end
              led_pwm_pkg::I2C_PTR: begin
                next_st.ptr      = st.shift;
                next_st.sda_oe_n = 1'b0;
                next_st.i2c      = led_pwm_pkg::I2C_ACK_PTR;
              end
              default: begin
                case (st.ptr)
                  led_pwm_pkg::OFS_CTRL:  next_st.ctrl  = st.shift;
                  led_pwm_pkg::OFS_COLOR: next_st.color = st.shift;
                  led_pwm_pkg::OFS_ILIM:  next_st.ilim  = st.shift;
                  default:                next_st.ilim  = st.ilim;
                endcase
                next_st.ptr      = st.ptr + 1'b1;
                next_st.sda_oe_n = 1'b0;
                next_st.i2c      = led_pwm_pkg::I2C_ACK_DATA;
              end
            endcase
          end
        end
        led_pwm_pkg::I2C_ACK_ADDR, led_pwm_pkg::I2C_ACK_PTR, led_pwm_pkg::I2C_ACK_DATA: begin
          if (scl_fall) begin
            if (st.i2c == led_pwm_pkg::I2C_ACK_ADDR && st.read_mode) begin
              next_st.shift    = read_data;
              next_st.sda_oe_n = read_data[7];
              next_st.ptr      = st.ptr + 1'b1;
              next_st.i2c      = led_pwm_pkg::I2C_RDATA;
            end else begin
              next_st.sda_oe_n = 1'b1;
              next_st.i2c      = (st.i2c == led_pwm_pkg::I2C_ACK_ADDR) ?
                                 led_pwm_pkg::I2C_PTR : led_pwm_pkg::I2C_WDATA;
            end
          end
        end
        led_pwm_pkg::I2C_RDATA: begin
          if (scl_rise) begin
            next_st.bit_cnt = st.bit_cnt + 1'b1;
          end else if (scl_fall) begin
            if (st.bit_cnt == led_pwm_pkg::BYTE_BITS) begin
              next_st.sda_oe_n = 1'b1;
              next_st.i2c      = led_pwm_pkg::I2C_RACK;
            end else begin
              next_st.shift    = {st.shift[6:0], 1'b0};
              next_st.sda_oe_n = st.shift[6];
            end
          end
        end
        led_pwm_pkg::I2C_RACK: begin
          if (scl_rise) begin
            next_st.master_nack = st.sda_sync;
          end else if (scl_fall) begin
            next_st.bit_cnt = 4'h0;
            if (st.master_nack) begin
              next_st.i2c = led_pwm_pkg::I2C_IDLE; // Master is done; wait for stop
            end else begin
              next_st.shift    = read_data;
              next_st.sda_oe_n = read_data[7];
              next_st.ptr      = st.ptr + 1'b1;
              next_st.i2c      = led_pwm_pkg::I2C_RDATA;
            end
          end
        end
        default: begin
          next_st.i2c = led_pwm_pkg::I2C_IDLE;
        end
      endcase
    end

    // External reset pin holds all but the synchronisers at defaults
    if (!st.ext_sync) begin
      next_st          = ST_RST;
      next_st.ext_meta = external_reset_n;
      next_st.ext_sync = st.ext_meta;
      next_st.scl_meta = scl_in;
      next_st.scl_sync = st.scl_meta;
      next_st.scl_prev = st.scl_sync;
      next_st.sda_meta = sda_in;
      next_st.sda_sync = st.sda_meta;
      next_st.sda_prev = st.sda_sync;
    end
  end
  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end
  assign sda_out          = st.sda_out;
  assign sda_oe_n         = st.sda_oe_n;
  assign sink_pin_oe_n    = st.sink_oe_n;
  assign sink_mode_select = st.sink_mode;
  assign current_codes    = st.cur;
  AST_MODE_FOLLOWS: assert property (@(posedge core_clk) disable iff (!resetn || !st.ext_sync)
    frame_end ##2 1'b1 |-> sink_mode_select == $past(st.ctrl[led_pwm_pkg::BIT_MODE], 2))
    else $error("sink mode does not follow control bit");
  AST_DISABLED_OFF: assert property (@(posedge core_clk) disable iff (!resetn || !st.ext_sync)
    !st.act_ctrl[led_pwm_pkg::BIT_EN] |=> sink_pin_oe_n == 3'h7)
    else $error("output lit while outputs disabled");
  AST_DIRECT_DRIVE: assert property (@(posedge core_clk) disable iff (!resetn || !st.ext_sync)
    st.act_ctrl[led_pwm_pkg::BIT_EN] && !st.act_ctrl[led_pwm_pkg::BIT_PWM]
    |=> sink_pin_oe_n == ~$past(st.act_ctrl[3:1]))
    else $error("direct mode output differs from enable bits");
  AST_ZERO_BRIGHT: assert property (@(posedge core_clk) disable iff (!resetn || !st.ext_sync)
    st.act_ctrl[7:6] == 2'h3 && bright == 3'h0 |=> sink_pin_oe_n == 3'h7)
    else $error("output lit at brightness zero");
  AST_OVERLAP_TOGETHER: assert property (@(posedge core_clk) disable iff (!resetn || !st.ext_sync)
    st.act_ctrl[7:6] == 2'h3 && st.act_ctrl[0] && st.frame_cnt == '0 && bright != 3'h0
    |=> sink_pin_oe_n == ~$past(st.act_ctrl[3:1]))
    else $error("overlapping outputs not lit together");
  AST_FRAME_TAIL_OFF: assert property (@(posedge core_clk) disable iff (!resetn || !st.ext_sync)
    st.act_ctrl[led_pwm_pkg::BIT_PWM] && st.frame_cnt >= win |=> sink_pin_oe_n == 3'h7)
    else $error("output lit after the lit window");
  AST_ONE_SLOT: assert property (@(posedge core_clk) disable iff (!resetn || !st.ext_sync)
    st.act_ctrl[7:6] == 2'h3 && !st.act_ctrl[0] |=> $countones(~sink_pin_oe_n) <= 1)
    else $error("two slots lit at once in time-sliced mode");
  AST_RED_CODE: assert property (@(posedge core_clk) disable iff (!resetn || !st.ext_sync)
    st.act_ctrl[7:6] == 2'h3 && !st.act_ctrl[0] && st.act_color[7:4] == 4'h0
    |=> sink_pin_oe_n.green && sink_pin_oe_n.blue)
    else $error("red-only colour lit green or blue");
  AST_SHADOW_HOLD: assert property (@(posedge core_clk) disable iff (!resetn || !st.ext_sync)
    !frame_end |=> $stable(st.act_ctrl) && $stable(st.act_color))
    else $error("active setting changed inside a frame");
  AST_CURRENT_CODES: assert property (@(posedge core_clk) disable iff (!resetn || !st.ext_sync)
    $changed(st.ilim) |=> current_codes == $past(st.ilim[5:0]))
    else $error("current codes do not track register");
endmodule : rgb_led_pwm_controller

//--- testbench/led_sink_model.sv
// Behavioural load for the three LED sink pins: counts lit cycles per colour.
// Assumes the sink pins are active low and settle between core clock edges.
`timescale 1ns/1ps
module led_sink_model (
  input  wire logic              core_clk,
  input  wire logic              clear,
  input  wire led_pwm_pkg::rgb_t sink_pin_oe_n,
  output int                     on_red,
  output int                     on_green,
  output int                     on_blue,
  output int                     both_lit
);
  // An LED conducts while its pin sinks; two at once breaks time slicing
  always_ff @(posedge core_clk) begin
    if (clear) begin
      on_red   <= 0;
      on_green <= 0;
      on_blue  <= 0;
      both_lit <= 0;
    end else begin
      on_red   <= on_red + int'(!sink_pin_oe_n.red);
      on_green <= on_green + int'(!sink_pin_oe_n.green);
      on_blue  <= on_blue + int'(!sink_pin_oe_n.blue);
      both_lit <= both_lit + int'($countones(~sink_pin_oe_n) > 1);
    end
  end
endmodule : led_sink_model

//--- testbench/rgb_led_pwm_controller_tb.sv
// Self-checking bench: 2-wire register access, then LED timing per frame.
// Assumes the short frame of 128 cycles; the LED model integrates one frame.
`timescale 1ns/1ps
`define CHECK(w, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", w, e, g); end end
module rgb_led_pwm_controller_tb;
  localparam int         F     = 128;
  localparam int         LIMIT = 90000;
  localparam logic [6:0] DEV   = 7'h35; // Arbitrary bus address
  // Colour shares in twelfths: red, green, blue nibbles
  localparam logic [11:0] SHARES [16] = '{12'hc00, 12'h0c0, 12'h00c, 12'h660, 12'h066,
    12'h606, 12'h444, 12'h633, 12'h363, 12'h363, 12'h336, 12'h930, 12'h093, 12'h390,
    12'h039, 12'h309};
  logic                         core_clk         = 1'b0;
  logic                         resetn           = 1'b0;
  logic                         external_reset_n = 1'b1;
  logic                         scl              = 1'b1;
  logic                         mst_sda          = 1'b1;
  logic                         clear            = 1'b0;
  logic                         sda_out;
  logic                         sda_oe_n;
  logic                         sink_mode_select;
  led_pwm_pkg::rgb_t            sink_pin_oe_n;
  led_pwm_pkg::current_codes_t  current_codes;
  int                           on_red, on_green, on_blue, both_lit;
  int                           n_errors = 0;
  int                           checked  = 0;
  int                           cycles   = 0;
  logic [7:0]                   x;
  logic                         ack;
  int                           r, g, b, w;
  // Open-drain bus: either party pulling low wins
  wire sda_wire = mst_sda & (sda_oe_n | sda_out);

  rgb_led_pwm_controller #(.FRAME_CYCLES(F), .DEV_ADDR(DEV)) uut (
    .core_clk(core_clk), .resetn(resetn), .external_reset_n(external_reset_n),
    .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .sink_pin_oe_n(sink_pin_oe_n), .sink_mode_select(sink_mode_select),
    .current_codes(current_codes));

  led_sink_model leds (.core_clk(core_clk), .clear(clear), .sink_pin_oe_n(sink_pin_oe_n),
    .on_red(on_red), .on_green(on_green), .on_blue(on_blue), .both_lit(both_lit));

  // Free-running core clock, 4 ns period
  always #2 core_clk = ~core_clk;

  // Hang guard, about 1.6 times the expected run length of some 56000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // Bus phases are 4 to 8 clocks, at least the 4-clock minimum, since the pins are synchronised
  task automatic bit_io(input logic bo, output logic bi);
    mst_sda <= bo;
    tick(6);
    scl <= 1'b1;
    tick(8);
    bi = sda_wire;
    scl <= 1'b0;
    tick(4);
  endtask : bit_io

  task automatic start_cond;
    tick(1);
    mst_sda <= 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(8);
    mst_sda <= 1'b0;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask : start_cond

  task automatic stop_cond;
    mst_sda <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(8);
    mst_sda <= 1'b1;
    tick(8);
  endtask : stop_cond

  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic sack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(mack, sack);
  endtask : xfer

  task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] t;
    logic       a0, a1, a2;
    start_cond();
    xfer({DEV, 1'b0}, 1'b1, t, a0);
    xfer(ofs, 1'b1, t, a1);
    xfer(d, 1'b1, t, a2);
    stop_cond();
    `CHECK("write acks", 3'b000, {a0, a1, a2})
  endtask : reg_write

  task automatic check_reg(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] t, d;
    logic       a0, a1, a2, nk;
    start_cond();
    xfer({DEV, 1'b0}, 1'b1, t, a0);
    xfer(ofs, 1'b1, t, a1);
    start_cond();
    xfer({DEV, 1'b1}, 1'b1, t, a2);
    xfer(8'hff, 1'b1, d, nk);
    stop_cond();
    `CHECK("read acks", 3'b000, {a0, a1, a2})
    `CHECK("register", exp, d)
  endtask : check_reg

  // Program, let two frame boundaries pass, then integrate one whole frame
  task automatic settle(input logic [7:0] ctrl, input logic [7:0] color);
    reg_write(led_pwm_pkg::OFS_COLOR, color);
    reg_write(led_pwm_pkg::OFS_CTRL, ctrl);
    tick(2 * F);
    clear <= 1'b1;
    tick(1);
    clear <= 1'b0;
    tick(F);
    #1;
  endtask : settle

  task automatic expect_on(input int er, input int eg, input int eb);
    `CHECK("red on", er, on_red)
    `CHECK("green on", eg, on_green)
    `CHECK("blue on", eb, on_blue)
  endtask : expect_on

  function automatic int count_on(input int win, input int lo, input int hi);
    int n = 0;
    for (int c = 0; c < F; c++) if (win * lo <= c * 12 && c * 12 < win * hi) n++;
    return n;
  endfunction : count_on

  function automatic int window(input int br);
    return (br == 0) ? 0 : (F >> (7 - br));
  endfunction : window

  // Main sequence
  initial begin
    tick(4);
    resetn <= 1'b1;
    tick(8);
    `CHECK("mode pin", 1'b1, sink_mode_select)
    `CHECK("sink pins", 3'b111, sink_pin_oe_n)
    check_reg(led_pwm_pkg::OFS_CTRL, 8'h20);
    check_reg(8'h03, 8'h00);
    start_cond();
    xfer({~DEV, 1'b0}, 1'b1, x, ack);
    stop_cond();
    `CHECK("foreign address ack", 1'b1, ack)
    $display("test reset and map done");
    reg_write(led_pwm_pkg::OFS_ILIM, 8'h1b);
    tick(2);
    `CHECK("current codes", 6'h1b, current_codes)
    reg_write(led_pwm_pkg::OFS_ILIM, 8'h24);
    check_reg(led_pwm_pkg::OFS_ILIM, 8'h24);
    `CHECK("current codes", 6'h24, current_codes)
    reg_write(led_pwm_pkg::OFS_CTRL, 8'h40);
    tick(2 * F);
    `CHECK("mode pin", 1'b0, sink_mode_select)
    $display("test current and mode done");
    for (int p = 0; p < 8; p++) begin
      settle(8'h40 | 8'(p << 1), 8'h0e);
      expect_on(p[2] ? F : 0, p[1] ? F : 0, p[0] ? F : 0);
    end
    settle(8'h8f, 8'h0e);
    expect_on(0, 0, 0);
    $display("test direct control done");
    for (int br = 0; br < 8; br++) begin
      settle(8'hcf, {4'h0, 3'(br), 1'b0});
      w = window(br);
      expect_on(w, w, w);
    end
    $display("test overlapping done");
    for (int c = 0; c < 16; c++) begin
      settle(8'hce, {4'(c), 3'h7, 1'b0});
      r = int'(SHARES[c][11:8]);
      g = int'(SHARES[c][7:4]);
      b = int'(SHARES[c][3:0]);
      expect_on(count_on(F, 0, r), count_on(F, r, r + g), count_on(F, r + g, r + g + b));
      `CHECK("slots overlap", 0, both_lit)
    end
    settle(8'hce, 8'h6c);
    w = window(6);
    expect_on(count_on(w, 0, 4), count_on(w, 4, 8), count_on(w, 8, 12));
    settle(8'hca, 8'h6e);
    expect_on(count_on(F, 0, 4), 0, count_on(F, 8, 12));
    $display("test time sliced done");
    external_reset_n <= 1'b0;
    tick(8);
    `CHECK("pins in reset", 3'b111, sink_pin_oe_n)
    `CHECK("mode in reset", 1'b1, sink_mode_select)
    `CHECK("codes in reset", 6'h00, current_codes)
    external_reset_n <= 1'b1;
    tick(8);
    check_reg(led_pwm_pkg::OFS_COLOR, 8'h00);
    $display("test external reset done");
    wrap_up();
  end
endmodule : rgb_led_pwm_controller_tb
